/* design/line_agg_pkg.sv */
/*
 * Constants, register map and state types for the line aggregation
 * discovery block. Assumes a single 10 MHz management clock.
 */
// Notes on behaviour
// - office-side endpoint availability map is read-only to management
// - customer-side writable availability map stores writes and reads them back
// - device without multi-endpoint aggregation holds exactly one availability bit set
// - customer-side links stay disabled until the availability map is programmed
// - customer-side device always implements the discovery identifier
// - remote get and set requests reach the discovery identifier atomically
// - simultaneous remote write requests are served one after another
// - thirty seconds of no active member link clears identifier and membership
// - outgoing messages carry the TDIM bonding parameter bit deasserted
// - discovery parameter bit in CLR equals local aggregation capable bit
// - CLR carries identifier in parameter bits, clear-if-same bit zero
// - set-if-clear loads identifier only while current identifier is zero
// - clear-if-same zeroes identifier when it equals the received value
package line_agg_pkg;

    localparam int N_EP = 32;
    localparam int DISC_W = 48;
    localparam int DISC_HI_W = DISC_W - 32;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_AVAIL = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_AGGR = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_DISC_LO = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_DISC_HI = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_LINK_UP = 8'h18;

    localparam int CTRL_AGG_CAP_BIT = 0;
    localparam int STATUS_PROG_BIT = 0;
    localparam int STATUS_TMR_BIT = 1;
    localparam int STATUS_BUSY_BIT = 2;

    localparam logic [N_EP-1:0] AVAIL_RST = 32'h0000_0001;
    localparam logic [N_EP-1:0] AGGR_RST = 32'h0000_0000;
    localparam logic [DISC_W-1:0] DISC_ZERO = 48'h0000_0000_0000;
    localparam logic CTRL_AGG_CAP_RST = 1'h1;

    // timing: the inactivity timeout counts millisecond ticks
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int TIMEOUT_S = 30;
    localparam int TIMEOUT_TICKS = TIMEOUT_S * 1000 / TICK_MS;
    localparam int TMR_W = 15;
    localparam int DIV_W = 14;

    typedef enum logic [0:0] {
        RMT_IDLE,
        RMT_ANSWER
    } rmt_state_e;

endpackage

/* design/level_sync3.sv */
/*
 * Three-stage synchroniser for a bus of levels from outside the clock
 * domain. Assumes each bit is a slow level; no multi-bit coherency.
 */
`timescale 1ns/10ps
`default_nettype none
module level_sync3 #(
    parameter int W = 1
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } sync_s;

    sync_s q;
    sync_s d;

    always_comb begin
        d = q;
        d.s1 = i_async;
        d.s2 = q.s1;
        d.s3 = q.s2;
        // a bit changes only once the second and third stage agree
        for (int i = 0; i < W; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.lvl[i] = q.s3[i];
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_level = q.lvl;
endmodule // level_sync3
`default_nettype wire

/* design/tick_divider.sv */
/*
 * Divider producing a one-cycle enable every CYCLES clocks, restartable.
 * Assumes CYCLES fits in line_agg_pkg::DIV_W bits.
 */
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
    parameter int CYCLES = line_agg_pkg::TICK_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_restart,
    output logic o_tick
);
    typedef struct packed {
        logic [line_agg_pkg::DIV_W-1:0] cnt;
        logic tick;
    } div_s;

    div_s q;
    div_s d;

    always_comb begin
        d = q;
        d.tick = 1'h0;
        if (i_restart) begin
            d.cnt = '0;
        end else if (q.cnt == line_agg_pkg::DIV_W'(CYCLES - 1)) begin
            d.cnt = '0;
            d.tick = 1'h1;
        end else begin
            d.cnt = q.cnt + 1'h1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_tick = q.tick;
endmodule // tick_divider
`default_nettype wire

/* design/line_agg_discovery.sv */
/*
 * Aggregation control and discovery registers of a line-endpoint PHY:
 * availability map, aggregate membership map, discovery identifier,
 * remote get / set-if-clear / clear-if-same service, the inactivity
 * timeout and the discovery fields placed in outgoing CLR messages.
 * Assumes remote requests and software strobes are on i_mclk; the
 * link-up map comes from PMA status pins and is synchronised here.
 */
`timescale 1ns/10ps
`default_nettype none
module line_agg_discovery #(
    parameter bit OFFICE_SIDE = 1'b0,
    parameter bit MULTI_EP = 1'b1,
    parameter bit MAP_WRITABLE = 1'b1,
    parameter int TICK_CYCLES = line_agg_pkg::TICK_CYCLES,
    parameter int TIMEOUT_TICKS = line_agg_pkg::TIMEOUT_TICKS
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // software register port
    input wire logic [line_agg_pkg::ADDR_W-1:0] i_addr,
    input wire logic [line_agg_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [line_agg_pkg::DATA_W-1:0] o_rdata,
    // physical link status, one bit per line endpoint
    input wire logic [line_agg_pkg::N_EP-1:0] i_link_up,
    // remote access from the line side
    input wire logic i_rmt_get,
    input wire logic i_rmt_set_if_clear,
    input wire logic i_rmt_clear_if_same,
    input wire logic [line_agg_pkg::DISC_W-1:0] i_rmt_value,
    output logic o_rmt_done,
    output logic [line_agg_pkg::DISC_W-1:0] o_rmt_rdata,
    // fields for the outgoing CLR message
    output logic o_clr_disc_spar,
    output logic o_clr_tdim_spar,
    output logic o_clr_clear_if_same,
    output logic [line_agg_pkg::DISC_W-1:0] o_clr_disc_npar,
    // link gating and membership toward the aggregation function
    output logic [line_agg_pkg::N_EP-1:0] o_link_enable,
    output logic [line_agg_pkg::N_EP-1:0] o_aggregate_map
);
    localparam bit AVAIL_WR_OK = MAP_WRITABLE && !OFFICE_SIDE && MULTI_EP;

    typedef struct packed {
        line_agg_pkg::rmt_state_e st;
        logic agg_cap;
        logic [line_agg_pkg::N_EP-1:0] avail;
        logic prog;
        logic [line_agg_pkg::N_EP-1:0] aggr;
        logic [line_agg_pkg::DISC_W-1:0] disc;
        logic [line_agg_pkg::DISC_HI_W-1:0] hi_shadow;
        logic pend_get;
        logic pend_sic;
        logic pend_cis;
        logic [line_agg_pkg::DISC_W-1:0] sic_val;
        logic [line_agg_pkg::DISC_W-1:0] cis_val;
        logic [line_agg_pkg::TMR_W-1:0] tmr;
        logic tmr_run;
        logic [line_agg_pkg::DATA_W-1:0] rdata;
        logic rmt_done;
        logic [line_agg_pkg::DISC_W-1:0] rmt_rdata;
        logic clr_disc_spar;
        logic clr_tdim_spar;
        logic clr_cis;
        logic [line_agg_pkg::DISC_W-1:0] clr_npar;
        logic [line_agg_pkg::N_EP-1:0] link_en;
        logic [line_agg_pkg::N_EP-1:0] aggr_out;
    } state_s;

    state_s q;
    state_s d;

    logic [line_agg_pkg::N_EP-1:0] link_up_s;
    logic idle_cond;
    logic ms_tick;

    level_sync3 #(
        .W(line_agg_pkg::N_EP)
    ) u_link_sync (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_async(i_link_up),
        .o_level(link_up_s)
    );

    // no member link is up while an identifier is held
    assign idle_cond = ((link_up_s & q.aggr) == '0) && (q.disc != line_agg_pkg::DISC_ZERO);

    tick_divider #(
        .CYCLES(TICK_CYCLES)
    ) u_ms_div (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_restart(!idle_cond),
        .o_tick(ms_tick)
    );

    always_comb begin
        d = q;
        d.rmt_done = 1'h0;
        d.rdata = '0;

        // inactivity timeout; any active member link restarts it
        if (!idle_cond) begin
            d.tmr = '0;
            d.tmr_run = 1'h0;
        end else begin
            d.tmr_run = 1'h1;
            if (ms_tick) begin
                if (q.tmr == line_agg_pkg::TMR_W'(TIMEOUT_TICKS - 1)) begin
                    d.disc = line_agg_pkg::DISC_ZERO;
                    d.tmr = '0;
                end else begin
                    d.tmr = q.tmr + 1'h1;
                end
            end
        end

        // remote engine: one request per pass so writes never overlap
        case (q.st)
            line_agg_pkg::RMT_IDLE: begin
                if (q.pend_cis) begin
                    if (d.disc == q.cis_val) begin
                        d.disc = line_agg_pkg::DISC_ZERO;
                    end
                    d.pend_cis = 1'h0;
                    d.st = line_agg_pkg::RMT_ANSWER;
                end else if (q.pend_sic) begin
                    if (d.disc == line_agg_pkg::DISC_ZERO) begin
                        d.disc = q.sic_val;
                    end
                    d.pend_sic = 1'h0;
                    d.st = line_agg_pkg::RMT_ANSWER;
                end else if (q.pend_get) begin
                    d.pend_get = 1'h0;
                    d.st = line_agg_pkg::RMT_ANSWER;
                end
            end
            line_agg_pkg::RMT_ANSWER: begin
                // whole identifier returned in one word, never torn
                d.rmt_rdata = q.disc;
                d.rmt_done = 1'h1;
                d.st = line_agg_pkg::RMT_IDLE;
            end
            default: begin
                d.st = line_agg_pkg::RMT_IDLE;
            end
        endcase

        // new requests are latched after service so a request that lands
        // in its own service cycle is kept for the next pass
        if (i_rmt_get) begin
            d.pend_get = 1'h1;
        end
        if (i_rmt_set_if_clear) begin
            d.pend_sic = 1'h1;
            d.sic_val = i_rmt_value;
        end
        if (i_rmt_clear_if_same) begin
            d.pend_cis = 1'h1;
            d.cis_val = i_rmt_value;
        end

        // software writes
        if (i_wr) begin
            if (i_addr == line_agg_pkg::ADDR_CTRL) begin
                d.agg_cap = i_wdata[line_agg_pkg::CTRL_AGG_CAP_BIT];
            end else if (i_addr == line_agg_pkg::ADDR_AVAIL) begin
                if (AVAIL_WR_OK) begin
                    d.avail = i_wdata;
                    d.prog = (i_wdata != '0);
                end
                // read-only on the office side and on single-endpoint parts
            end else if (i_addr == line_agg_pkg::ADDR_AGGR) begin
                d.aggr = i_wdata;
            end
        end

        if (!AVAIL_WR_OK) begin
            d.avail = line_agg_pkg::AVAIL_RST;
            d.prog = 1'h1;
        end

        // membership cannot outlive the identifier
        if (d.disc == line_agg_pkg::DISC_ZERO) begin
            d.aggr = line_agg_pkg::AGGR_RST;
        end

        // software reads; the high half is snapshotted with the low half
        if (i_rd) begin
            if (i_addr == line_agg_pkg::ADDR_CTRL) begin
                d.rdata[line_agg_pkg::CTRL_AGG_CAP_BIT] = q.agg_cap;
            end else if (i_addr == line_agg_pkg::ADDR_STATUS) begin
                d.rdata[line_agg_pkg::STATUS_PROG_BIT] = q.prog;
                d.rdata[line_agg_pkg::STATUS_TMR_BIT] = q.tmr_run;
                d.rdata[line_agg_pkg::STATUS_BUSY_BIT] = (q.st != line_agg_pkg::RMT_IDLE)
                    || q.pend_get || q.pend_sic || q.pend_cis;
            end else if (i_addr == line_agg_pkg::ADDR_AVAIL) begin
                d.rdata = q.avail;
            end else if (i_addr == line_agg_pkg::ADDR_AGGR) begin
                d.rdata = q.aggr;
            end else if (i_addr == line_agg_pkg::ADDR_DISC_LO) begin
                d.rdata = q.disc[31:0];
                d.hi_shadow = q.disc[line_agg_pkg::DISC_W-1:32];
            end else if (i_addr == line_agg_pkg::ADDR_DISC_HI) begin
                d.rdata[line_agg_pkg::DISC_HI_W-1:0] = q.hi_shadow;
            end else if (i_addr == line_agg_pkg::ADDR_LINK_UP) begin
                d.rdata = link_up_s;
            end
        end

        // outgoing CLR fields follow the registered state
        d.clr_disc_spar = q.agg_cap;
        d.clr_tdim_spar = 1'h0;
        d.clr_cis = 1'h0;
        d.clr_npar = q.disc;

        // links held off until the availability map is programmed
        d.link_en = q.prog ? q.avail : '0;
        d.aggr_out = q.aggr;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            q <= '0;
            q.st <= line_agg_pkg::RMT_IDLE;
            q.agg_cap <= line_agg_pkg::CTRL_AGG_CAP_RST;
            q.avail <= line_agg_pkg::AVAIL_RST;
            q.prog <= !AVAIL_WR_OK;
            q.aggr <= line_agg_pkg::AGGR_RST;
            q.disc <= line_agg_pkg::DISC_ZERO;
        end else begin
            q <= d;
        end
    end

    assign o_rdata = q.rdata;
    assign o_rmt_done = q.rmt_done;
    assign o_rmt_rdata = q.rmt_rdata;
    assign o_clr_disc_spar = q.clr_disc_spar;
    assign o_clr_tdim_spar = q.clr_tdim_spar;
    assign o_clr_clear_if_same = q.clr_cis;
    assign o_clr_disc_npar = q.clr_npar;
    assign o_link_enable = q.link_en;
    assign o_aggregate_map = q.aggr_out;
endmodule // line_agg_discovery
`default_nettype wire

/* test/line_agg_discovery_asserts.sv */
/*
 * Port checker for line_agg_discovery, bound to every instance.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
module line_agg_discovery_asserts (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [line_agg_pkg::ADDR_W-1:0] i_addr,
    input wire logic [line_agg_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [line_agg_pkg::DATA_W-1:0] o_rdata,
    input wire logic i_rmt_get,
    input wire logic o_rmt_done,
    input wire logic [line_agg_pkg::DISC_W-1:0] o_rmt_rdata,
    input wire logic o_clr_tdim_spar,
    input wire logic o_clr_clear_if_same,
    input wire logic [line_agg_pkg::DISC_W-1:0] o_clr_disc_npar,
    input wire logic [line_agg_pkg::N_EP-1:0] o_link_enable,
    input wire logic [line_agg_pkg::N_EP-1:0] o_aggregate_map
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);
    property p_tdim_low;
        o_clr_tdim_spar == 1'b0;
    endproperty
    a_tdim_low: assert property (p_tdim_low) else $error("tdim bit set");
    property p_same_low;
        o_clr_clear_if_same == 1'b0;
    endproperty
    a_same_low: assert property (p_same_low) else $error("clear-if-same bit set");
    property p_npar_match;
        o_rmt_done |-> o_clr_disc_npar == o_rmt_rdata;
    endproperty
    a_npar_match: assert property (p_npar_match) else $error("npar differs from answer");
    property p_get_served;
        i_rmt_get |-> ##[1:8] o_rmt_done;
    endproperty
    a_get_served: assert property (p_get_served) else $error("get not answered");
    property p_done_gap;
        o_rmt_done |=> !o_rmt_done && $stable(o_rmt_rdata);
    endproperty
    a_done_gap: assert property (p_done_gap) else $error("answers not serial");
    property p_aggr_cleared;
        o_clr_disc_npar == '0 |=> o_aggregate_map == '0;
    endproperty
    a_aggr_cleared: assert property (p_aggr_cleared) else $error("membership without id");
    property p_link_follow;
        i_wr && i_addr == line_agg_pkg::ADDR_AVAIL |=> ##1 o_link_enable == $past(i_wdata, 2);
    endproperty
    a_link_follow: assert property (p_link_follow) else $error("link enable wrong");
    property p_rdata_idle;
        !i_rd |=> o_rdata == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
endmodule // line_agg_discovery_asserts
bind line_agg_discovery line_agg_discovery_asserts chk_u (.i_mclk, .i_rst_n, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_rmt_get, .o_rmt_done, .o_rmt_rdata, .o_clr_tdim_spar, .o_clr_clear_if_same,
    .o_clr_disc_npar, .o_link_enable, .o_aggregate_map);
`default_nettype wire

/* test/line_agg_office_model.sv */
/*
 * Office-side remote access model: raises get, set-if-clear and
 * clear-if-same requests and gathers the answers.
 * Assumes each call starts just after a rising clock edge.
 */
`timescale 1ns/10ps
`default_nettype none
module line_agg_office_model (
    input wire logic i_mclk,
    input wire logic i_done,
    input wire logic [47:0] i_rdata,
    output logic o_get,
    output logic o_set,
    output logic o_clear,
    output logic [47:0] o_value
);
    initial begin
        {o_clear, o_set, o_get} = 3'h0;
        o_value = 48'h0;
    end
    // kind bit 0 get, bit 1 set-if-clear, bit 2 clear-if-same; all may go at once
    task automatic exchange(input logic [2:0] kind, input logic [47:0] v, output logic [47:0] r,
        output int n);
        int t;
        n = 0;
        r = 48'h0;
        {o_clear, o_set, o_get} <= kind;
        o_value <= v;
        @(posedge i_mclk);
        {o_clear, o_set, o_get} <= 3'h0;
        // released value line never keeps the old value
        o_value <= ~v;
        for (t = 0; t < 8; t++) begin
            @(posedge i_mclk);
            #1;
            if (i_done === 1'b1) begin
                n++;
                r = i_rdata;
            end
        end
    endtask
endmodule // line_agg_office_model
`default_nettype wire

/* test/line_agg_discovery_tb.sv */
/*
 * Self-checking bench for line_agg_discovery with the office model.
 * Assumes shortened timer parameters: 4-cycle tick, 8 ticks.
 */
`timescale 1ns/10ps
`default_nettype none
module line_agg_discovery_tb;
    localparam logic [47:0] V1 = 48'hA5C3_0F12_7E01;
    localparam logic [47:0] V2 = 48'h1234_5678_9ABC;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] i_link_up = 32'h0000_0001;
    logic [31:0] o_rdata, o_link_enable, o_aggregate_map;
    logic i_rmt_get, i_rmt_set_if_clear, i_rmt_clear_if_same, o_rmt_done;
    logic o_clr_disc_spar, o_clr_tdim_spar, o_clr_clear_if_same;
    logic [47:0] i_rmt_value, o_rmt_rdata, o_clr_disc_npar, r;
    int mismatches = 0;
    int checks = 0;
    int n;
    int k;
    always #50 i_mclk = ~i_mclk;
    line_agg_discovery #(.TICK_CYCLES(4), .TIMEOUT_TICKS(8)) dut_u (.i_mclk, .i_rst_n, .i_addr, .i_wdata,
        .i_wr, .i_rd, .o_rdata, .i_link_up, .i_rmt_get, .i_rmt_set_if_clear, .i_rmt_clear_if_same,
        .i_rmt_value, .o_rmt_done, .o_rmt_rdata, .o_clr_disc_spar, .o_clr_tdim_spar, .o_clr_clear_if_same,
        .o_clr_disc_npar, .o_link_enable, .o_aggregate_map);
    line_agg_office_model office_u (.i_mclk, .i_done(o_rmt_done), .i_rdata(o_rmt_rdata),
        .o_get(i_rmt_get), .o_set(i_rmt_set_if_clear), .o_clear(i_rmt_clear_if_same), .o_value(i_rmt_value));
    task automatic stop_test();
        if (mismatches == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        chk({16'h0, o_rdata}, {16'h0, exp});
    endtask
    task automatic t_regs();
        rd(line_agg_pkg::ADDR_AVAIL, 32'h1);
        rd(line_agg_pkg::ADDR_STATUS, 32'h0);
        chk({16'h0, o_link_enable}, 48'h0);
        chk({47'h0, o_clr_disc_spar}, 48'h1);
        chk({47'h0, o_clr_tdim_spar}, 48'h0);
        wr(line_agg_pkg::ADDR_AVAIL, 32'h5);
        rd(line_agg_pkg::ADDR_AVAIL, 32'h5);
        chk({16'h0, o_link_enable}, 48'h5);
        rd(line_agg_pkg::ADDR_STATUS, 32'h1);
        wr(line_agg_pkg::ADDR_CTRL, 32'h0);
        @(posedge i_mclk);
        #1;
        chk({47'h0, o_clr_disc_spar}, 48'h0);
        wr(line_agg_pkg::ADDR_CTRL, 32'h1);
        wr(line_agg_pkg::ADDR_DISC_LO, 32'hFFFF_FFFF);
        rd(line_agg_pkg::ADDR_DISC_LO, 32'h0);
        rd(8'hFC, 32'h0);
        rd(line_agg_pkg::ADDR_LINK_UP, 32'h1);
    endtask
    task automatic t_get_set();
        office_u.exchange(3'h1, V2, r, n);
        chk(r, 48'h0);
        chk(48'(n), 48'h1);
        office_u.exchange(3'h2, V1, r, n);
        chk(r, V1);
        wr(line_agg_pkg::ADDR_AGGR, 32'h1);
        office_u.exchange(3'h2, V2, r, n);
        chk(r, V1);
        chk(o_clr_disc_npar, V1);
        rd(line_agg_pkg::ADDR_DISC_LO, V1[31:0]);
        rd(line_agg_pkg::ADDR_DISC_HI, {16'h0, V1[47:32]});
        rd(line_agg_pkg::ADDR_AGGR, 32'h1);
    endtask
    task automatic t_clear_multi();
        office_u.exchange(3'h4, V2, r, n);
        chk(r, V1);
        office_u.exchange(3'h4, V1, r, n);
        chk(r, 48'h0);
        chk({16'h0, o_aggregate_map}, 48'h0);
        office_u.exchange(3'h2, V1, r, n);
        chk(r, V1);
        // clear, then set, then get: any order with set before clear ends with a different answer
        office_u.exchange(3'h7, V1, r, n);
        chk(48'(n), 48'h3);
        chk(r, V1);
        wr(line_agg_pkg::ADDR_AGGR, 32'h1);
    endtask
    task automatic t_timeout();
        i_link_up <= 32'h0;
        repeat (24) @(posedge i_mclk);
        i_link_up <= 32'h1;
        repeat (8) @(posedge i_mclk);
        i_link_up <= 32'h0;
        repeat (24) @(posedge i_mclk);
        rd(line_agg_pkg::ADDR_STATUS, 32'h3);
        chk(o_clr_disc_npar, V1);
        for (k = 0; k < 60 && o_aggregate_map !== 32'h0; k++) begin
            @(posedge i_mclk);
            #1;
        end
        // a spent bound is counted here; the run still ends in the one closing report
        if (k == 60) begin
            mismatches++;
        end
        chk(o_clr_disc_npar, 48'h0);
    endtask
    initial begin
        repeat (5) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        #1;
        t_regs();
        t_get_set();
        t_clear_multi();
        t_timeout();
        stop_test();
    end
endmodule // line_agg_discovery_tb
`default_nettype wire
